// file: hdl/ebc_core.sv
// external bus controller: apb registers, cycle sequencer and pin control
//
// Functional notes
// - eight 2-Mbyte areas, one active-low select for accessed area
// - address strobe low only while address outputs valid in cycle
// - read strobe low throughout an external read
// - upper strobe writes high lane, lower strobe writes low lane
// - wait pin held low stretches the cycle while low
// - wait pin enable setting, disabled after reset
// - bus request low releases all bus pins to high impedance
// - acknowledge low for the whole released state
// - bus release enable setting, disabled after reset, request ignored
// - per-area width 8 or 16, reset 16 in mode 4 else 8
// - per-area access 2 or 3 states, reset 3
// - per-area 0..3 program waits for 3-state access, reset 3
// - idle cycle options read-write and read-read areas, reset both
// - area 0 basic or burst rom, 1/2 state, 4/8 words
// - address output range seventeen steps, bits above not driven
// - reset range bits 20..0 modes 4,5; bits 7..0 modes 6,7
// - mode from pins, settings live in modes 4..6, mode 7 no bus
// - each select pin driven only when its direction bit is one
// - finish current cycle before release, resume after withdrawal
// - cycle lasts 2 states, or 3 plus program waits
// - enabled area select low for the whole bus cycle
// - burst rom mode forces area 0 to 16-bit width
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ebc_core #(
	parameter int AW = ebc_pkg::ADDR_W,
	parameter int DW = ebc_pkg::DATA_W,
	parameter int NA = ebc_pkg::NUM_AREAS
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	input  wire logic [2:0]    op_mode_pins,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          req_valid,
	input  wire logic          req_write,
	input  wire logic          req_word,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic [DW-1:0] req_wdata,
	output logic               req_done,
	output logic      [DW-1:0] req_rdata,
	output logic      [AW-1:0] addr_out,
	output logic      [AW-1:0] addr_oe,
	input  wire logic [DW-1:0] data_in,
	output logic      [DW-1:0] data_out,
	output logic               data_oe,
	output logic      [NA-1:0] area_sel_n,
	output logic      [NA-1:0] area_sel_oe,
	output logic               addr_strobe_n,
	output logic               read_strobe_n,
	output logic               upper_write_strobe_n,
	output logic               lower_write_strobe_n,
	output logic               strobe_oe,
	input  wire logic          wait_n,
	input  wire logic          release_request_n,
	output logic               release_ack_n
);
	localparam int TIMER_W_L = ebc_pkg::TIMER_W;

	// settings
	logic [NA-1:0]   width8;
	logic [NA-1:0]   astate3;
	logic [2*NA-1:0] pwait;
	logic [1:0]      idle_mode;
	logic [2:0]      burst_cfg;
	logic            rel_en;
	logic            wait_en;
	logic [4:0]      addr_range;
	logic [NA-1:0]   cs_dir;

	// mode strap and sequencer state
	logic            strap_done;
	logic [2:0]      op_mode;
	logic            ext_ok;
	ebc_pkg::ebc_state_t st;
	logic [AW-1:0]   cur_addr;
	logic [2:0]      cur_area;
	logic            cur_write;
	logic            cur_hi;
	logic            cur_lo;
	logic [2:0]      cur_len;
	logic            second;
	logic            last_read;
	logic [2:0]      last_area;
	logic            burst_live;
	logic [AW-1:0]   burst_next;
	logic [3:0]      burst_cnt;

	// combinational helpers
	logic            apb_wr;
	logic            apb_rd;
	logic            unmapped;
	logic [31:0]     rd_mux;
	logic [2:0]      req_area;
	logic            is_burst;
	logic            eff_w8;
	logic            split;
	logic [AW-1:0]   phase_addr;
	logic            need_gap;
	logic            burst_hit;
	logic [2:0]      next_len;
	logic [TIMER_W_L-1:0] t_cnt;
	logic            t_last;
	logic            t_load;
	logic            pin_hold;
	logic            cyc_end;
	logic            start;
	logic            reject;
	logic            go_rel;
	logic            own_pins;
	logic [5:0]      top_bit;
	logic [3:0]      burst_max;

	// apb slave with one wait state so read data comes from a flop
	assign apb_rd = psel && penable && !pready && !pwrite;
	assign apb_wr = psel && penable && pready && pwrite;

	always_comb begin
		unmapped = 1'b0;
		rd_mux   = 32'h0000_0000;
		unique case (paddr)
			ebc_pkg::OFF_WIDTH:  rd_mux[NA-1:0] = width8;
			ebc_pkg::OFF_ASTATE: rd_mux[NA-1:0] = astate3;
			ebc_pkg::OFF_WAIT:   rd_mux[2*NA-1:0] = pwait;
			ebc_pkg::OFF_BUSCTL: rd_mux[4:0] = {burst_cfg, idle_mode};
			ebc_pkg::OFF_RELCTL: rd_mux[1:0] = {wait_en, rel_en};
			ebc_pkg::OFF_RANGE:  rd_mux[4:0] = addr_range;
			ebc_pkg::OFF_CSDIR:  rd_mux[NA-1:0] = cs_dir;
			ebc_pkg::OFF_STATUS: rd_mux[5:0] = {st, ext_ok, op_mode};
			default:             unmapped = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			if (apb_rd) begin
				prdata <= rd_mux;
			end
		end
	end

	assign pslverr = pready && unmapped;

	// mode pins caught on the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done <= 1'b0;
			op_mode    <= ebc_pkg::MODE_SINGLE;
		end else if (ce && !strap_done) begin
			strap_done <= 1'b1;
			op_mode    <= op_mode_pins;
		end
	end

	// modes below 4 are not bus modes, so they get no external bus either
	assign ext_ok = strap_done && op_mode >= ebc_pkg::MODE_EXT16
		&& op_mode != ebc_pkg::MODE_SINGLE;

	// settings; mode-dependent defaults load with the strap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			width8     <= ebc_pkg::RST_WIDTH_M57;
			addr_range <= ebc_pkg::RST_RANGE_M67;
		end else if (ce) begin
			if (!strap_done) begin
				width8 <= (op_mode_pins == ebc_pkg::MODE_EXT16) ?
					ebc_pkg::RST_WIDTH_M4 : ebc_pkg::RST_WIDTH_M57;
				addr_range <= (op_mode_pins == ebc_pkg::MODE_EXT16
					|| op_mode_pins == ebc_pkg::MODE_EXT8) ?
					ebc_pkg::RST_RANGE_M45 : ebc_pkg::RST_RANGE_M67;
			end else if (apb_wr && paddr == ebc_pkg::OFF_WIDTH) begin
				width8 <= pwdata[NA-1:0];
			end else if (apb_wr && paddr == ebc_pkg::OFF_RANGE) begin
				// out-of-range codes clamp to the full bus
				addr_range <= (pwdata[4:0] > ebc_pkg::RANGE_MAX) ?
					ebc_pkg::RANGE_MAX : pwdata[4:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			astate3   <= ebc_pkg::RST_ASTATE;
			pwait     <= ebc_pkg::RST_WAIT;
			idle_mode <= ebc_pkg::RST_IDLE;
			burst_cfg <= ebc_pkg::RST_BURST;
			rel_en    <= ebc_pkg::RST_RELCTL[ebc_pkg::REL_EN_BIT];
			wait_en   <= ebc_pkg::RST_RELCTL[ebc_pkg::WAIT_EN_BIT];
			cs_dir    <= ebc_pkg::RST_CSDIR;
		end else if (ce && apb_wr) begin
			unique case (paddr)
				ebc_pkg::OFF_ASTATE: astate3 <= pwdata[NA-1:0];
				ebc_pkg::OFF_WAIT:   pwait <= pwdata[2*NA-1:0];
				ebc_pkg::OFF_BUSCTL: begin
					idle_mode <= pwdata[ebc_pkg::BUSCTL_IDLE_LSB +: 2];
					burst_cfg <= pwdata[ebc_pkg::BUSCTL_BURST_LSB +: 3];
				end
				ebc_pkg::OFF_RELCTL: begin
					rel_en  <= pwdata[ebc_pkg::REL_EN_BIT];
					wait_en <= pwdata[ebc_pkg::WAIT_EN_BIT];
				end
				ebc_pkg::OFF_CSDIR:  cs_dir <= pwdata[NA-1:0];
				default: ;
			endcase
		end
	end

	// request decode for the access about to start
	assign req_area = req_addr[ebc_pkg::AREA_LSB +: 3];
	assign is_burst = burst_cfg[ebc_pkg::BURST_EN_BIT] && req_area == 3'h0;
	assign eff_w8   = width8[req_area] && !is_burst;
	assign split    = eff_w8 && req_word;
	assign phase_addr = second ? (req_addr | AW'(1)) : req_addr;
	assign burst_max = burst_cfg[ebc_pkg::BURST_MAX8_BIT] ?
		ebc_pkg::BURST_WORDS_8 : ebc_pkg::BURST_WORDS_4;
	assign burst_hit = is_burst && !req_write && burst_live
		&& req_addr == burst_next && burst_cnt < burst_max;

	always_comb begin
		need_gap = 1'b0;
		if (last_read && req_write && idle_mode[ebc_pkg::IDLE_RW_BIT]) begin
			need_gap = 1'b1;
		end
		if (last_read && !req_write && req_area != last_area
			&& idle_mode[ebc_pkg::IDLE_AREA_BIT]) begin
			need_gap = 1'b1;
		end
	end

	always_comb begin
		if (burst_hit) begin
			next_len = burst_cfg[ebc_pkg::BURST_CYC2_BIT] ?
				ebc_pkg::BURST_SLOW : ebc_pkg::BURST_FAST;
		end else if (astate3[req_area]) begin
			next_len = ebc_pkg::LONG_STATES
				+ {1'b0, pwait[2*req_area +: 2]};
		end else begin
			next_len = ebc_pkg::SHORT_STATES;
		end
	end

	// sequencing decisions
	assign go_rel = st == ebc_pkg::EBC_ST_IDLE && ext_ok && rel_en
		&& !release_request_n;
	assign reject = st == ebc_pkg::EBC_ST_IDLE && strap_done && !ext_ok
		&& req_valid;
	assign start = st == ebc_pkg::EBC_ST_IDLE && ext_ok && !go_rel
		&& req_valid && !need_gap;
	// pin wait is only heard in the final state and only when enabled
	assign pin_hold = st == ebc_pkg::EBC_ST_BUS && t_last && wait_en
		&& !wait_n;
	assign cyc_end = st == ebc_pkg::EBC_ST_BUS && t_last && !pin_hold;
	assign t_load = start;
	assign req_done = reject || (cyc_end && (second || !(cur_hi && split)));

	ebc_state_timer #(
		.W(TIMER_W_L)
	) u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.load     (t_load),
		.load_val (next_len - 3'h1),
		.hold     (pin_hold),
		.cnt      (t_cnt),
		.last     (t_last)
	);

	// main state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ebc_pkg::EBC_ST_IDLE;
		end else if (ce) begin
			unique case (st)
				ebc_pkg::EBC_ST_IDLE: begin
					if (go_rel) begin
						st <= ebc_pkg::EBC_ST_REL;
					end else if (ext_ok && req_valid && need_gap) begin
						st <= ebc_pkg::EBC_ST_GAP;
					end else if (start) begin
						st <= ebc_pkg::EBC_ST_BUS;
					end
				end
				ebc_pkg::EBC_ST_BUS: begin
					if (cyc_end) begin
						st <= ebc_pkg::EBC_ST_IDLE;
					end
				end
				ebc_pkg::EBC_ST_GAP: st <= ebc_pkg::EBC_ST_IDLE;
				ebc_pkg::EBC_ST_REL: begin
					if (release_request_n) begin
						st <= ebc_pkg::EBC_ST_IDLE;
					end
				end
			endcase
		end
	end

	// cycle fields latched at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_addr  <= '0;
			cur_area  <= 3'h0;
			cur_write <= 1'b0;
			cur_hi    <= 1'b0;
			cur_lo    <= 1'b0;
			cur_len   <= ebc_pkg::SHORT_STATES;
			data_out  <= '0;
		end else if (ce && start) begin
			cur_addr  <= phase_addr;
			cur_area  <= req_area;
			cur_write <= req_write;
			cur_len   <= next_len;
			if (eff_w8) begin
				// 8-bit areas use the upper lane; words go high byte first
				cur_hi   <= 1'b1;
				cur_lo   <= 1'b0;
				data_out <= {(req_word && !second) ? req_wdata[15:8] : req_wdata[7:0],
					8'h00};
			end else begin
				cur_hi   <= req_word || !req_addr[0];
				cur_lo   <= req_word || req_addr[0];
				data_out <= req_word ? req_wdata :
					(req_addr[0] ? {8'h00, req_wdata[7:0]} : {req_wdata[7:0], 8'h00});
			end
		end
	end

	// byte pairing, read data and history for idle-cycle decisions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second    <= 1'b0;
			req_rdata <= '0;
			last_read <= 1'b0;
			last_area <= 3'h0;
		end else if (ce) begin
			if (reject) begin
				req_rdata <= '0;
			end else if (cyc_end) begin
				last_read <= !cur_write;
				last_area <= cur_area;
				second    <= cur_hi && !cur_lo && split && !second;
				if (!cur_write) begin
					if (cur_hi && cur_lo) begin
						req_rdata <= data_in;
					end else if (split) begin
						if (second) begin
							req_rdata[7:0] <= data_in[15:8];
						end else begin
							req_rdata[15:8] <= data_in[15:8];
						end
					end else begin
						req_rdata <= {8'h00, cur_hi ? data_in[15:8] : data_in[7:0]};
					end
				end
			end else if (st == ebc_pkg::EBC_ST_GAP) begin
				last_read <= 1'b0;
			end
		end
	end

	// burst rom tracking for area 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_live <= 1'b0;
			burst_next <= '0;
			burst_cnt  <= 4'h0;
		end else if (ce) begin
			if (start) begin
				if (is_burst && !req_write) begin
					burst_live <= 1'b1;
					burst_next <= req_addr + AW'(2);
					burst_cnt  <= burst_hit ? burst_cnt + 4'h1 : 4'h1;
				end else begin
					burst_live <= 1'b0;
				end
			end else if (st == ebc_pkg::EBC_ST_REL) begin
				burst_live <= 1'b0;
			end
		end
	end

	// pin control
	assign own_pins = ext_ok && st != ebc_pkg::EBC_ST_REL;
	assign top_bit  = {1'b0, ebc_pkg::RANGE_BASE_BIT} + {1'b0, addr_range};
	assign addr_out = cur_addr;
	assign strobe_oe = own_pins;
	assign data_oe  = own_pins && st == ebc_pkg::EBC_ST_BUS && cur_write;
	assign addr_strobe_n = !(st == ebc_pkg::EBC_ST_BUS);
	assign read_strobe_n = !(st == ebc_pkg::EBC_ST_BUS && !cur_write);
	// write strobes skip the first state so data settles before them
	assign upper_write_strobe_n = !(st == ebc_pkg::EBC_ST_BUS && cur_write && cur_hi
		&& t_cnt != cur_len - 3'h1);
	assign lower_write_strobe_n = !(st == ebc_pkg::EBC_ST_BUS && cur_write && cur_lo
		&& t_cnt != cur_len - 3'h1);
	assign release_ack_n = !(st == ebc_pkg::EBC_ST_REL);

	genvar gi;
	generate
		for (gi = 0; gi < AW; gi++) begin : g_addr
			assign addr_oe[gi] = own_pins && gi <= int'(top_bit);
		end
		for (gi = 0; gi < NA; gi++) begin : g_sel
			assign area_sel_oe[gi] = own_pins && cs_dir[gi];
			assign area_sel_n[gi]  = !(st == ebc_pkg::EBC_ST_BUS
				&& cur_area == 3'(gi) && cs_dir[gi]);
		end
	endgenerate
endmodule
`default_nettype wire

// file: pkg/ebc_pkg.sv
// constants, register map and state codes of the external bus controller
package ebc_pkg;
	localparam int ADDR_W    = 24;
	localparam int DATA_W    = 16;
	localparam int NUM_AREAS = 8;
	localparam int AREA_LSB  = 21;
	localparam int TIMER_W   = 3;

	// register byte offsets
	localparam logic [7:0] OFF_WIDTH  = 8'h00;
	localparam logic [7:0] OFF_ASTATE = 8'h04;
	localparam logic [7:0] OFF_WAIT   = 8'h08;
	localparam logic [7:0] OFF_BUSCTL = 8'h0c;
	localparam logic [7:0] OFF_RELCTL = 8'h10;
	localparam logic [7:0] OFF_RANGE  = 8'h14;
	localparam logic [7:0] OFF_CSDIR  = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;

	// field positions
	localparam int BUSCTL_IDLE_LSB  = 0;
	localparam int BUSCTL_BURST_LSB = 2;
	localparam int IDLE_RW_BIT      = 0;
	localparam int IDLE_AREA_BIT    = 1;
	localparam int BURST_MAX8_BIT   = 0;
	localparam int BURST_CYC2_BIT   = 1;
	localparam int BURST_EN_BIT     = 2;
	localparam int REL_EN_BIT       = 0;
	localparam int WAIT_EN_BIT      = 1;
	localparam int STATUS_MODE_LSB  = 0;
	localparam int STATUS_EXT_BIT   = 3;
	localparam int STATUS_ST_LSB    = 4;

	// reset values
	localparam logic [7:0]  RST_WIDTH_M4  = 8'h00;
	localparam logic [7:0]  RST_WIDTH_M57 = 8'hff;
	localparam logic [7:0]  RST_ASTATE    = 8'hff;
	localparam logic [15:0] RST_WAIT      = 16'hffff;
	localparam logic [1:0]  RST_IDLE      = 2'h3;
	localparam logic [2:0]  RST_BURST     = 3'h0;
	localparam logic [1:0]  RST_RELCTL    = 2'h0;
	localparam logic [4:0]  RST_RANGE_M45 = 5'h0d;
	localparam logic [4:0]  RST_RANGE_M67 = 5'h00;
	localparam logic [4:0]  RANGE_MAX     = 5'h10;
	localparam logic [7:0]  RST_CSDIR     = 8'h00;

	// address range base bit and access lengths in states
	localparam logic [4:0] RANGE_BASE_BIT = 5'h07;
	localparam logic [2:0] SHORT_STATES   = 3'h2;
	localparam logic [2:0] LONG_STATES    = 3'h3;
	localparam logic [2:0] BURST_FAST     = 3'h1;
	localparam logic [2:0] BURST_SLOW     = 3'h2;
	localparam logic [3:0] BURST_WORDS_4  = 4'h4;
	localparam logic [3:0] BURST_WORDS_8  = 4'h8;

	// operating modes
	localparam logic [2:0] MODE_EXT16  = 3'h4;
	localparam logic [2:0] MODE_EXT8   = 3'h5;
	localparam logic [2:0] MODE_EXTROM = 3'h6;
	localparam logic [2:0] MODE_SINGLE = 3'h7;

	typedef enum logic [1:0] {
		EBC_ST_IDLE = 2'b00,
		EBC_ST_BUS  = 2'b01,
		EBC_ST_GAP  = 2'b10,
		EBC_ST_REL  = 2'b11
	} ebc_state_t;
endpackage

// file: hdl/ebc_state_timer.sv
// down counter that times the states of one external bus cycle
`timescale 1ns/1ns
`default_nettype none
module ebc_state_timer #(
	parameter int W = 3
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         hold,
	output logic      [W-1:0] cnt,
	output logic              last
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (ce) begin
			if (load) begin
				cnt <= load_val;
			end else if (cnt != '0 && !hold) begin
				cnt <= cnt - W'(1);
			end
		end
	end

	assign last = (cnt == '0);
endmodule
`default_nettype wire

// file: dv/ebc_core_chk.sv
// pin-level assertions of the external bus controller
`timescale 1ns/1ns
`default_nettype none
module ebc_core_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [23:0] addr_out,
	input wire logic [23:0] addr_oe,
	input wire logic        data_oe,
	input wire logic [7:0]  area_sel_n,
	input wire logic [7:0]  area_sel_oe,
	input wire logic        addr_strobe_n,
	input wire logic        read_strobe_n,
	input wire logic        upper_write_strobe_n,
	input wire logic        lower_write_strobe_n,
	input wire logic        strobe_oe,
	input wire logic        release_request_n,
	input wire logic        release_ack_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_ONE_SEL: assert property ($onehot0(~area_sel_n))
		else $error("more than one area select low");
	AST_SEL_AREA: assert property ((area_sel_n != 8'hff) |-> !area_sel_n[addr_out[23:21]])
		else $error("select low for a foreign area");
	AST_ADDR_HOLD: assert property ($fell(addr_strobe_n) |=> $stable(addr_out))
		else $error("address moved under the strobe");
	AST_RD_QUIET: assert property (!read_strobe_n |-> !data_oe && upper_write_strobe_n
		&& lower_write_strobe_n)
		else $error("read strobe with data driven");
	AST_WR_DRIVE: assert property ((!upper_write_strobe_n || !lower_write_strobe_n)
		|-> data_oe && read_strobe_n && !addr_strobe_n)
		else $error("write strobe without data drive");
	AST_REL_FLOAT: assert property (!release_ack_n |-> addr_oe == 24'h0 && !data_oe
		&& area_sel_oe == 8'h00 && !strobe_oe)
		else $error("pins driven while released");
	AST_ACK_STAY: assert property (!release_ack_n && !release_request_n |=> !release_ack_n)
		else $error("acknowledge left while still requested");
	AST_ACK_START: assert property ($fell(release_ack_n)
		|-> !$past(release_request_n) && $past(addr_strobe_n))
		else $error("released without request or mid cycle");
	AST_ACK_END: assert property ($rose(release_ack_n) |-> $past(release_request_n))
		else $error("release ended while requested");
	AST_RANGE: assert property ((addr_oe != 24'h0) |-> addr_oe[7:0] == 8'hff
		&& ((addr_oe + 24'h1) & addr_oe) == 24'h0)
		else $error("address enables not a low range");
endmodule

bind ebc_core ebc_core_chk i_ebc_core_chk (.pclk, .presetn, .addr_out, .addr_oe, .data_oe,
	.area_sel_n, .area_sel_oe, .addr_strobe_n, .read_strobe_n, .upper_write_strobe_n,
	.lower_write_strobe_n, .strobe_oe, .release_request_n, .release_ack_n);
`default_nettype wire

// file: dv/ebc_mem_model.sv
// external memory: answers reads from its address, records written lanes
`timescale 1ns/1ns
`default_nettype none
module ebc_mem_model (
	input  wire logic        pclk,
	input  wire logic [23:0] addr_out,
	input  wire logic [7:0]  area_sel_n,
	input  wire logic        read_strobe_n,
	input  wire logic        upper_write_strobe_n,
	input  wire logic        lower_write_strobe_n,
	input  wire logic [15:0] data_out,
	output logic      [15:0] data_in,
	output logic      [15:0] last_wr
);
	logic [15:0] held = 16'h0;
	wire         rd_on = !read_strobe_n && area_sel_n != 8'hff;

	// undriven bus flips every cycle, so a stale capture never matches
	assign data_in = rd_on ? {addr_out[7:0] ^ 8'h5a, addr_out[7:0]} : ~held;
	always @(posedge pclk) begin
		held <= data_in;
		if (!upper_write_strobe_n) begin
			last_wr[15:8] <= data_out[15:8];
		end
		if (!lower_write_strobe_n) begin
			last_wr[7:0] <= data_out[7:0];
		end
	end
endmodule
`default_nettype wire

// file: dv/ebc_core_tb_top.sv
// self-checking bench of the external bus controller
`timescale 1ns/1ns
`default_nettype none
module ebc_core_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic        req_valid, req_write, req_word, req_done, data_oe, strobe_oe;
	logic        addr_strobe_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
	logic        wait_n, release_request_n, release_ack_n;
	logic [7:0]  paddr, area_sel_n, area_sel_oe;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] req_addr, addr_out, addr_oe;
	logic [15:0] req_wdata, req_rdata, data_in, data_out, last_wr;
	int          bad_count, check_count, cyc, n;
	logic [2:0]  op_mode;

	ebc_core i_ebc_core (.pclk, .presetn, .ce(1'b1), .op_mode_pins(op_mode),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid,
		.req_write, .req_word, .req_addr, .req_wdata, .req_done, .req_rdata, .addr_out,
		.addr_oe, .data_in, .data_out, .data_oe, .area_sel_n, .area_sel_oe, .addr_strobe_n,
		.read_strobe_n, .upper_write_strobe_n, .lower_write_strobe_n, .strobe_oe, .wait_n,
		.release_request_n, .release_ack_n);
	ebc_mem_model i_ebc_mem_model (.pclk, .addr_out, .area_sel_n, .read_strobe_n,
		.upper_write_strobe_n, .lower_write_strobe_n, .data_out, .data_in, .last_wr);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic end_of_test();
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// n ends as the cycle count from the taking edge to the done state
	task automatic req(input logic w, input logic wd, input logic [23:0] a,
			input logic [15:0] d);
		n = 0;
		@(posedge pclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_word <= wd;
		req_addr <= a;
		req_wdata <= d;
		do begin
			@(negedge pclk);
			n++;
		end while (req_done !== 1'b1);
		@(posedge pclk);
		req_valid <= 1'b0;
		@(negedge pclk);
		rd = {16'h0, req_rdata};
		n--;
	endtask

	task automatic t_defaults();
		logic [31:0] exp [8] = '{32'h0, 32'hff, 32'hffff, 32'h3, 32'h0, 32'hd, 32'h0, 32'hc};
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, exp[i]);
		end
		apb(1'b1, 8'h20, 32'h5);
		chk(32'(se), 32'h1);
		chk(32'(addr_oe), 32'h1fffff);
		chk(32'(area_sel_oe), 32'h0);
	endtask

	task automatic t_cycles();
		apb(1'b1, ebc_pkg::OFF_CSDIR, 32'hff);
		apb(1'b1, ebc_pkg::OFF_ASTATE, 32'hfd);
		chk(32'(area_sel_oe), 32'hff);
		req(1'b1, 1'b1, 24'h400002, 16'h1234);
		chk(n, 6);
		chk(32'(last_wr), 32'h1234);
		apb(1'b1, ebc_pkg::OFF_WAIT, 32'hffcf);
		req(1'b1, 1'b0, 24'h400003, 16'h00ab);
		chk(n, 3);
		chk(32'(last_wr), 32'h12ab);
		req(1'b0, 1'b1, 24'h200010, 16'h0);
		chk(n, 2);
		chk(rd, 32'h4a10);
		req(1'b0, 1'b1, 24'h400004, 16'h0);
		// gap state plus the idle state every cycle passes through
		chk(n, 5);
		chk(rd, 32'h5e04);
		apb(1'b1, ebc_pkg::OFF_BUSCTL, 32'h0);
		req(1'b0, 1'b1, 24'h200010, 16'h0);
		chk(n, 2);
		req(1'b0, 1'b1, 24'h400004, 16'h0);
		chk(n, 3);
		apb(1'b1, ebc_pkg::OFF_WIDTH, 32'h2);
		req(1'b0, 1'b1, 24'h200010, 16'h0);
		chk(n, 5);
		chk(rd, 32'h4a4b);
	endtask

	task automatic t_wait();
		@(posedge pclk);
		wait_n <= 1'b0;
		req(1'b0, 1'b1, 24'h400004, 16'h0);
		chk(n, 3);
		apb(1'b1, ebc_pkg::OFF_RELCTL, 32'h2);
		fork
			req(1'b0, 1'b1, 24'h400004, 16'h0);
			begin
				repeat (6) @(posedge pclk);
				wait_n <= 1'b1;
			end
		join
		chk(n, 5);
	endtask

	task automatic t_release();
		@(posedge pclk);
		release_request_n <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(32'(release_ack_n), 32'h1);
		apb(1'b1, ebc_pkg::OFF_RELCTL, 32'h1);
		repeat (3) @(negedge pclk);
		chk(32'(release_ack_n), 32'h0);
		chk({addr_oe, area_sel_oe}, 32'h0);
		fork
			req(1'b0, 1'b1, 24'h200010, 16'h0);
			begin
				repeat (8) @(posedge pclk);
				release_request_n <= 1'b1;
			end
		join
		chk(rd, 32'h4a4b);
		chk(32'(n > 8), 32'h1);
		chk(32'(release_ack_n), 32'h1);
	endtask

	task automatic t_range();
		logic [4:0]  v [3] = '{5'h10, 5'h00, 5'h1f};
		logic [23:0] e [3] = '{24'hffffff, 24'hff, 24'hffffff};
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, ebc_pkg::OFF_RANGE, 32'(v[i]));
			repeat (2) @(negedge pclk);
			chk(32'(addr_oe), 32'(e[i]));
		end
	endtask

	// area 0 set 8-bit, burst mode must still read it as 16-bit
	task automatic t_burst();
		apb(1'b1, ebc_pkg::OFF_WIDTH, 32'h3);
		apb(1'b1, ebc_pkg::OFF_BUSCTL, 32'h10);
		req(1'b0, 1'b1, 24'h000000, 16'h0);
		chk(n, 6);
		chk(rd, 32'h5a00);
		req(1'b0, 1'b1, 24'h000002, 16'h0);
		chk(n, 1);
		chk(rd, 32'h5802);
	endtask

	task automatic t_mode7();
		@(posedge pclk);
		presetn <= 1'b0;
		op_mode <= ebc_pkg::MODE_SINGLE;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, ebc_pkg::OFF_WIDTH, 32'h0);
		chk(rd, 32'hff);
		apb(1'b0, ebc_pkg::OFF_RANGE, 32'h0);
		chk(rd, 32'h0);
		chk(32'(addr_oe), 32'h0);
		req(1'b0, 1'b1, 24'h200010, 16'h0);
		chk(n, 0);
		chk(rd, 32'h0);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{req_valid, req_write, req_word, req_addr, req_wdata} = '0;
		wait_n = 1'b1;
		release_request_n = 1'b1;
		op_mode = ebc_pkg::MODE_EXT16;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_defaults();
		t_cycles();
		t_wait();
		t_release();
		t_burst();
		t_range();
		t_mode7();
		end_of_test();
	end
endmodule
`default_nettype wire
